// *** common/sfbc_map.vh ***
`ifndef SFBC_MAP_VH
`define SFBC_MAP_VH
// instruction codes
`define SFBC_CMD_UNLOCK     8'h06
`define SFBC_CMD_LOCK       8'h04
`define SFBC_CMD_READ_STAT  8'h05
`define SFBC_CMD_STORE_STAT 8'h01
`define SFBC_CMD_PAGE_PROG  8'h02
`define SFBC_CMD_TWO_PROG   8'hA2
`define SFBC_CMD_OTP_PROG   8'h42
`define SFBC_CMD_WIPE_SMALL 8'h20
`define SFBC_CMD_WIPE_LARGE 8'hD8
`define SFBC_CMD_WIPE_ALL   8'hC7
`define SFBC_CMD_SLEEP      8'hB9
`define SFBC_CMD_WAKE       8'hAB
// internal cycle kinds
`define SFBC_OP_NONE        3'h0
`define SFBC_OP_PROG        3'h1
`define SFBC_OP_TWO_PROG    3'h2
`define SFBC_OP_OTP         3'h3
`define SFBC_OP_STAT        3'h4
`define SFBC_OP_WIPE_SMALL  3'h5
`define SFBC_OP_WIPE_LARGE  3'h6
`define SFBC_OP_WIPE_ALL    3'h7
// status field positions
`define SFBC_ST_BUSY        0
`define SFBC_ST_UNLOCK      1
`define SFBC_ST_BP_LO       2
`define SFBC_ST_BP_HI       4
`define SFBC_ST_GUARD       7
`define SFBC_STAT_RESET     8'h00
// timing counts in clk_i cycles
`define SFBC_PROG_CYCLES    16'd0500
`define SFBC_STAT_CYCLES    16'd0200
`define SFBC_WIPE_CYCLES    16'd2000
`define SFBC_PAGE_BYTES     9'd256
`endif

// *** hw/sfbc_sync.v ***
`timescale 1ns/10ps
// two flip-flop synchroniser for a bus of pin levels
module sfbc_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,
  input  wire             reset_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk_i) begin
    if (reset_i) begin
      meta   <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // sfbc_sync

// *** hw/sfbc_ctrl.v ***
`timescale 1ns/10ps
`include "sfbc_map.vh"

// How it works
// - chip select high deselects and tri-states the output line
// - after deselect stay active until internal cycle ends, then standby
// - chip select low selects the device and makes it active
// - no instruction accepted before first chip select falling edge
// - pause tri-states output and ignores clock and input
// - write-guard pin low with status guard bit 7 set freezes the three protect size bits
// - input sampled on rising clock, output changed on falling clock
// - unlock, then four-byte page program plus data starts program cycle
// - page program takes up to 256 bytes in one page, clears bits
// - two-pin program takes two bits per clock, up to 256 bytes
// - target bytes must be erased to all ones first
// - small, large and whole-array wipe each start an erase cycle
// - busy flag reported throughout every internal cycle
// - sleep instruction enters deep power-down until wake instruction
// - in deep power-down write, program and erase are ignored
// - output line is sampled as input during two-pin program
// - modifying commands need the unlock latch; completion clears it
module sfbc_ctrl (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        chip_sel_n_i,
  input  wire        serial_clk_i,
  input  wire        serial_in_pin_i,
  input  wire        serial_out_pin_i,
  input  wire        hold_n_i,
  input  wire        write_guard_n_i,
  output reg         serial_out_pin_o,
  output reg         serial_out_pin_oe_n_o,
  output reg         active_power_o,
  output reg         deep_sleep_o,
  output reg         cycle_active_flag_o,
  output reg         write_unlock_latch_o,
  output reg  [2:0]  protect_size_o,
  output reg  [2:0]  op_kind_o,
  output reg  [23:0] op_addr_o,
  output reg  [7:0]  prog_data_o,
  output reg         prog_data_valid_o
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [5:0] pins_s;
  wire       cs_n_s   = pins_s[0];
  wire       sck_s    = pins_s[1];
  wire       din_s    = pins_s[2];
  wire       dio_s    = pins_s[3];
  wire       hold_n_s = pins_s[4];
  wire       guard_s  = pins_s[5];

  sfbc_sync #(.WIDTH(6)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({write_guard_n_i, hold_n_i, serial_out_pin_i,
               serial_in_pin_i, serial_clk_i, chip_sel_n_i}),
    .sync_o  (pins_s)
  );

  // ------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------
  reg  sck_d;
  reg  cs_n_d;
  reg  armed;
  reg  paused;
  reg  read_live;
  wire cs_fall  = cs_n_d & ~cs_n_s;
  wire cs_rise  = ~cs_n_d & cs_n_s;
  wire sck_rise = ~sck_d & sck_s & ~paused;
  wire sck_fall = sck_d & ~sck_s & ~paused;

  // ------------------------------------------------------------
  // shifting state
  // ------------------------------------------------------------
  localparam PH_CMD  = 2'd0;
  localparam PH_ADDR = 2'd1;
  localparam PH_DATA = 2'd2;
  localparam PH_IDLE = 2'd3;

  reg [1:0]  phase;
  reg [7:0]  shreg;
  reg [2:0]  bitcnt;
  reg [7:0]  cmd;
  reg [1:0]  addr_bytes;
  reg [23:0] addr;
  reg [8:0]  nbytes;
  reg        byte_seen;
  reg [7:0]  status_q;
  reg [7:0]  out_sh;
  reg [15:0] busy_cnt;
  reg [2:0]  pend_op;
  reg [7:0]  new_stat;

  wire two_pin = (cmd == `SFBC_CMD_TWO_PROG) && (phase == PH_DATA);
  wire [7:0] next_shreg = two_pin ? {shreg[5:0], dio_s, din_s}
                                  : {shreg[6:0], din_s};
  wire byte_done = two_pin ? (bitcnt[1:0] == 2'd3) : (bitcnt == 3'd7);
  wire busy = cycle_active_flag_o;

  // a modifying command may run only when unlocked, idle and awake
  function allow;
    input unl;
    input bsy;
    input slp;
    begin
      allow = unl & ~bsy & ~slp;
    end
  endfunction

  function [2:0] op_of;
    input [7:0] c;
    begin
      case (c)
        `SFBC_CMD_PAGE_PROG:  op_of = `SFBC_OP_PROG;
        `SFBC_CMD_TWO_PROG:   op_of = `SFBC_OP_TWO_PROG;
        `SFBC_CMD_OTP_PROG:   op_of = `SFBC_OP_OTP;
        `SFBC_CMD_STORE_STAT: op_of = `SFBC_OP_STAT;
        `SFBC_CMD_WIPE_SMALL: op_of = `SFBC_OP_WIPE_SMALL;
        `SFBC_CMD_WIPE_LARGE: op_of = `SFBC_OP_WIPE_LARGE;
        `SFBC_CMD_WIPE_ALL:   op_of = `SFBC_OP_WIPE_ALL;
        default:              op_of = `SFBC_OP_NONE;
      endcase
    end
  endfunction

  function [15:0] len_of;
    input [2:0] op;
    begin
      case (op)
        `SFBC_OP_STAT:                     len_of = `SFBC_STAT_CYCLES;
        `SFBC_OP_PROG, `SFBC_OP_TWO_PROG,
        `SFBC_OP_OTP:                      len_of = `SFBC_PROG_CYCLES;
        default:                           len_of = `SFBC_WIPE_CYCLES;
      endcase
    end
  endfunction

  wire [2:0] cmd_op = op_of(cmd);

  // ------------------------------------------------------------
  // main sequencer
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      sck_d                 <= 1'b0;
      // same level as the synchroniser's reset: no false select edge
      cs_n_d                <= 1'b0;
      armed                 <= 1'b0;
      paused                <= 1'b0;
      read_live             <= 1'b0;
      phase                 <= PH_IDLE;
      shreg                 <= 8'h00;
      bitcnt                <= 3'd0;
      cmd                   <= 8'h00;
      addr_bytes            <= 2'd0;
      addr                  <= 24'h00_0000;
      nbytes                <= 9'd0;
      byte_seen             <= 1'b0;
      status_q              <= `SFBC_STAT_RESET;
      new_stat              <= 8'h00;
      out_sh                <= 8'h00;
      busy_cnt              <= 16'd0;
      pend_op               <= `SFBC_OP_NONE;
      serial_out_pin_o      <= 1'b0;
      serial_out_pin_oe_n_o <= 1'b1;
      active_power_o        <= 1'b0;
      deep_sleep_o          <= 1'b0;
      cycle_active_flag_o   <= 1'b0;
      write_unlock_latch_o  <= 1'b0;
      protect_size_o        <= 3'd0;
      op_kind_o             <= `SFBC_OP_NONE;
      op_addr_o             <= 24'h00_0000;
      prog_data_o           <= 8'h00;
      prog_data_valid_o     <= 1'b0;
    end else begin
      cs_n_d            <= cs_n_s;
      prog_data_valid_o <= 1'b0;
      active_power_o    <= ~cs_n_s | busy;
      protect_size_o    <= status_q[`SFBC_ST_BP_HI:`SFBC_ST_BP_LO];
      if (!paused)
        sck_d <= sck_s;
      // pause only while selected; clock edges skipped meanwhile
      if (cs_n_s)
        paused <= 1'b0;
      else if (sck_s == 1'b0 || paused)
        paused <= ~hold_n_s;
      // internal cycle countdown
      if (busy) begin
        if (busy_cnt == 16'd1) begin
          cycle_active_flag_o  <= 1'b0;
          write_unlock_latch_o <= 1'b0;
          op_kind_o            <= `SFBC_OP_NONE;
          if (pend_op == `SFBC_OP_STAT &&
              !(guard_s == 1'b0 && status_q[`SFBC_ST_GUARD]))
            status_q <= {new_stat[7:2], 2'b00};
        end
        busy_cnt <= busy_cnt - 16'd1;
      end
      status_q[`SFBC_ST_BUSY]   <= busy;
      status_q[`SFBC_ST_UNLOCK] <= write_unlock_latch_o;
      if (cs_fall) begin
        armed  <= 1'b1;
        phase  <= PH_CMD;
        bitcnt <= 3'd0;
      end
      if (cs_n_s) begin
        serial_out_pin_oe_n_o <= 1'b1;
        read_live             <= 1'b0;
        if (!cs_fall)
          phase <= PH_IDLE;
      end else if (paused) begin
        serial_out_pin_oe_n_o <= 1'b1;
      end else if (sck_fall && cmd == `SFBC_CMD_READ_STAT &&
                   phase == PH_DATA) begin
        serial_out_pin_o      <= out_sh[7];
        out_sh                <= {out_sh[6:0], out_sh[7]};
        serial_out_pin_oe_n_o <= 1'b0;
        read_live             <= 1'b1;
      end else if (read_live) begin
        serial_out_pin_oe_n_o <= 1'b0;
      end
      if (sck_rise && !cs_n_s && armed && phase != PH_IDLE) begin
        shreg  <= next_shreg;
        bitcnt <= two_pin ? bitcnt + 3'd1 + {2'b00, byte_done} : bitcnt + 3'd1;
        if (byte_done) begin
          bitcnt <= 3'd0;
          case (phase)
            PH_CMD: begin
              cmd       <= next_shreg;
              nbytes    <= 9'd0;
              byte_seen <= 1'b0;
              out_sh    <= {status_q[7:1], busy};
              if (deep_sleep_o && next_shreg != `SFBC_CMD_WAKE)
                phase <= PH_IDLE;
              else if (next_shreg == `SFBC_CMD_STORE_STAT ||
                       next_shreg == `SFBC_CMD_READ_STAT)
                phase <= PH_DATA;
              else if (op_of(next_shreg) != `SFBC_OP_NONE &&
                       next_shreg != `SFBC_CMD_WIPE_ALL) begin
                phase      <= PH_ADDR;
                addr_bytes <= 2'd0;
              end else
                phase <= PH_DATA;
            end
            PH_ADDR: begin
              addr       <= {addr[15:0], next_shreg};
              addr_bytes <= addr_bytes + 2'd1;
              if (addr_bytes == 2'd2)
                phase <= PH_DATA;
            end
            PH_DATA: begin
              byte_seen <= 1'b1;
              if (cmd == `SFBC_CMD_STORE_STAT)
                new_stat <= next_shreg;
              if ((cmd_op == `SFBC_OP_PROG || cmd_op == `SFBC_OP_TWO_PROG ||
                   cmd_op == `SFBC_OP_OTP) &&
                  allow(write_unlock_latch_o, busy, deep_sleep_o)) begin
                prog_data_o       <= next_shreg;
                prog_data_valid_o <= 1'b1;
                op_addr_o         <= {addr[23:8], addr[7:0] + nbytes[7:0]};
                if (nbytes != `SFBC_PAGE_BYTES)
                  nbytes <= nbytes + 9'd1;
              end
            end
            default: phase <= PH_IDLE;
          endcase
        end
      end
      // instruction executes at chip select rise on a byte boundary
      if (cs_rise && bitcnt == 3'd0 && !paused &&
          (phase == PH_DATA || phase == PH_ADDR)) begin
        if (deep_sleep_o) begin
          if (cmd == `SFBC_CMD_WAKE)
            deep_sleep_o <= 1'b0;
        end else if (cmd == `SFBC_CMD_SLEEP && !busy) begin
          deep_sleep_o <= 1'b1;
        end else if (cmd == `SFBC_CMD_UNLOCK && !busy) begin
          write_unlock_latch_o <= 1'b1;
        end else if (cmd == `SFBC_CMD_LOCK && !busy) begin
          write_unlock_latch_o <= 1'b0;
        end else if (cmd_op != `SFBC_OP_NONE && phase == PH_DATA &&
                     allow(write_unlock_latch_o, busy, deep_sleep_o) &&
                     (byte_seen || cmd_op >= `SFBC_OP_WIPE_SMALL)) begin
          cycle_active_flag_o <= 1'b1;
          pend_op             <= cmd_op;
          op_kind_o           <= cmd_op;
          busy_cnt            <= len_of(cmd_op);
          if (cmd_op >= `SFBC_OP_WIPE_SMALL)
            op_addr_o <= addr;
        end
      end
    end
  end
endmodule // sfbc_ctrl

// *** test/sfbc_ctrl_checker.sv ***
`timescale 1ns/10ps
`include "sfbc_map.vh"
module sfbc_ctrl_checker (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       chip_sel_n_i,
  input wire logic       hold_n_i,
  input wire logic       serial_out_pin_oe_n_o,
  input wire logic       active_power_o,
  input wire logic       deep_sleep_o,
  input wire logic       cycle_active_flag_o,
  input wire logic       write_unlock_latch_o,
  input wire logic [2:0] op_kind_o,
  input wire logic       prog_data_valid_o
);
  int unsigned busy_len;
  always @(posedge clk_i)
    busy_len <= (cycle_active_flag_o && !reset_i) ? busy_len + 1 : 0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_cs_high; chip_sel_n_i [*5]; endsequence
  sequence s_cs_low; !chip_sel_n_i [*5]; endsequence
  sequence s_paused; (!hold_n_i && !chip_sel_n_i) [*5]; endsequence
  a_desel_tristate: assert property (s_cs_high |-> serial_out_pin_oe_n_o)
    else $error("output driven while deselected");
  a_select_active: assert property (s_cs_low |-> active_power_o)
    else $error("selected but not active");
  a_idle_standby: assert property (
    (chip_sel_n_i && !cycle_active_flag_o) [*5] |-> !active_power_o)
    else $error("idle but still active");
  a_busy_active: assert property (
    cycle_active_flag_o [*2] |-> active_power_o)
    else $error("busy but not active");
  a_pause_tristate: assert property (s_paused |-> serial_out_pin_oe_n_o)
    else $error("output driven in pause");
  a_busy_length: assert property ($fell(cycle_active_flag_o) |->
    (busy_len == 200 || busy_len == 500 || busy_len == 2000))
    else $error("busy length wrong");
  a_busy_kind: assert property (
    cycle_active_flag_o |-> op_kind_o != `SFBC_OP_NONE)
    else $error("busy without cycle kind");
  a_start_unlock: assert property (
    $rose(cycle_active_flag_o) |-> $past(write_unlock_latch_o))
    else $error("cycle started without unlock");
  a_end_lock: assert property (
    $fell(cycle_active_flag_o) |-> ##[0:1] !write_unlock_latch_o)
    else $error("unlock latch kept after cycle");
  a_sleep_quiet: assert property (
    deep_sleep_o && !cycle_active_flag_o |=> !cycle_active_flag_o)
    else $error("cycle started in deep sleep");
  a_pulse_single: assert property (
    prog_data_valid_o |=> !prog_data_valid_o)
    else $error("byte pulse too long");
endmodule // sfbc_ctrl_checker

bind sfbc_ctrl sfbc_ctrl_checker sfbc_ctrl_checker_inst (.clk_i, .reset_i,
  .chip_sel_n_i, .hold_n_i, .serial_out_pin_oe_n_o, .active_power_o,
  .deep_sleep_o, .cycle_active_flag_o, .write_unlock_latch_o, .op_kind_o,
  .prog_data_valid_o);

// *** test/sfbc_master.sv ***
`timescale 1ns/10ps
module sfbc_master (
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o,
  output logic dq1_o,
  output logic dq1_en_o,
  output logic hold_n_o
);
  logic mode3;
  // select held low from power-up, so the first frame has no select edge
  initial begin
    mode3 = 1'h0;
    cs_n_o = 1'h0;
    sclk_o = 1'h0;
    mosi_o = 1'h0;
    dq1_o = 1'h0;
    dq1_en_o = 1'h0;
    hold_n_o = 1'h1;
  end
  // pause with clock low, clock and input wiggled meanwhile
  task automatic pause();
    hold_n_o = 1'h0;
    #62.5;
    sclk_o = 1'h1;
    mosi_o = ~mosi_o;
    #62.5;
    sclk_o = 1'h0;
    mosi_o = ~mosi_o;
    #62.5;
    hold_n_o = 1'h1;
    #62.5;
  endtask
  // whole bytes msb first, data set while clock low
  task automatic xfer(input logic [7:0] q[$], input int two_from,
                      input int hold_bit);
    int n;
    int i;
    int two;
    n = 0;
    sclk_o = mode3;
    cs_n_o = 1'h0;
    #62.5;
    foreach (q[k]) begin
      two = (k >= two_from) ? 1 : 0;
      for (i = 7; i >= 0; i = i - 1 - two) begin
        sclk_o = 1'h0;
        mosi_o = q[k][i - two];
        dq1_o = q[k][i];
        dq1_en_o = two[0];
        if (n == hold_bit) pause();
        n = n + 1;
        #62.5;
        sclk_o = 1'h1;
        #62.5;
      end
    end
    sclk_o = mode3;
    #62.5;
    cs_n_o = 1'h1;
    mosi_o = ~mosi_o;
    dq1_en_o = 1'h0;
    #250;
  endtask
endmodule // sfbc_master

// *** test/serial_flash_bus_control_tb.sv ***
`timescale 1ns/10ps
`include "sfbc_map.vh"
module serial_flash_bus_control_tb;
  logic        clk_i = 1'h0;
  logic        reset_i = 1'h1;
  logic        write_guard_n_i = 1'h1;
  wire         chip_sel_n_i, serial_clk_i, serial_in_pin_i, hold_n_i;
  wire         dq1_drv, dq1_en, serial_out_pin_i, serial_out_pin_o;
  wire         serial_out_pin_oe_n_o, active_power_o, deep_sleep_o;
  wire         cycle_active_flag_o, write_unlock_latch_o, prog_data_valid_o;
  wire  [2:0]  protect_size_o, op_kind_o;
  wire  [23:0] op_addr_o;
  wire  [7:0]  prog_data_o;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          run_len = 0;
  logic        prev_busy = 1'h0;
  logic [7:0]  got[$];
  logic [7:0]  rd_sh = 8'h00;
  logic [7:0]  wipe[3] = '{8'h20, 8'hD8, 8'hC7};
  logic [2:0]  kinds[3] = '{`SFBC_OP_WIPE_SMALL, `SFBC_OP_WIPE_LARGE,
                            `SFBC_OP_WIPE_ALL};
  // released wire shows the inverse of the last driven bit
  assign serial_out_pin_i = !serial_out_pin_oe_n_o ? serial_out_pin_o :
                            dq1_en ? dq1_drv : ~dq1_drv;
  always #4 clk_i = ~clk_i;
  sfbc_master sfbc_master_inst (.cs_n_o(chip_sel_n_i), .sclk_o(serial_clk_i),
    .mosi_o(serial_in_pin_i), .dq1_o(dq1_drv), .dq1_en_o(dq1_en),
    .hold_n_o(hold_n_i));
  sfbc_ctrl sfbc_ctrl_inst (.clk_i, .reset_i, .chip_sel_n_i, .serial_clk_i,
    .serial_in_pin_i, .serial_out_pin_i, .hold_n_i, .write_guard_n_i,
    .serial_out_pin_o, .serial_out_pin_oe_n_o, .active_power_o, .deep_sleep_o,
    .cycle_active_flag_o, .write_unlock_latch_o, .protect_size_o, .op_kind_o,
    .op_addr_o, .prog_data_o, .prog_data_valid_o);
  always @(negedge clk_i) begin
    prev_busy <= cycle_active_flag_o;
    if (cycle_active_flag_o === 1'h1)
      run_len <= (prev_busy === 1'h1) ? run_len + 1 : 1;
    if (prog_data_valid_o === 1'h1)
      got.push_back(prog_data_o);
  end
  // master side capture of the data-out wire, skipped while paused
  always @(posedge serial_clk_i)
    if (!chip_sel_n_i && hold_n_i)
      rd_sh <= {rd_sh[6:0], serial_out_pin_i};
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [23:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] q[$], input int two, input int hb);
    got.delete();
    sfbc_master_inst.xfer(q, two, hb);
  endtask
  task automatic op(input logic [2:0] k, input int len);
    int c;
    c = 0;
    check("kind", op_kind_o, k);
    check("active", active_power_o, 1'h1);
    while (cycle_active_flag_o !== 1'h0 && c < 3000) begin
      @(negedge clk_i);
      c++;
    end
    repeat (2) @(negedge clk_i);
    check("length", run_len, len);
    check("unlock", write_unlock_latch_o, 1'h0);
    check("standby", active_power_o, 1'h0);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk_i);
    reset_i = 1'h0;
    #100;
    send('{8'h06}, 99, 99);
    check("armed", write_unlock_latch_o, 1'h0);
    send('{8'h06}, 99, 99);
    check("latch", write_unlock_latch_o, 1'h1);
    check("idle", active_power_o, 1'h0);
    send('{8'h02, 8'h00, 8'h01, 8'hF0, 8'hA5, 8'h3C}, 99, 13);
    op(`SFBC_OP_PROG, 500);
    check("paddr", op_addr_o, 24'h00_01F1);
    check("byte0", got[0], 8'hA5);
    check("byte1", got[1], 8'h3C);
    send('{8'h20, 8'h00, 8'h10, 8'h00}, 99, 99);
    check("locked", cycle_active_flag_o, 1'h0);
    for (int k = 0; k < 3; k++) begin
      send('{8'h06}, 99, 99);
      if (k == 2) send('{wipe[k]}, 99, 99);
      else send('{wipe[k], 8'h00, 8'h20, 8'h00}, 99, 99);
      op(kinds[k], 2000);
      if (k < 2) check("waddr", op_addr_o, 24'h00_2000);
    end
    sfbc_master_inst.mode3 = 1'h1;
    send('{8'h06}, 99, 99);
    send('{8'hA2, 8'h00, 8'h02, 8'h00, 8'h96}, 4, 99);
    op(`SFBC_OP_TWO_PROG, 500);
    check("dual", got[0], 8'h96);
    check("daddr", op_addr_o, 24'h00_0200);
    sfbc_master_inst.mode3 = 1'h0;
    send('{8'h06}, 99, 99);
    send('{8'h01, 8'h94}, 99, 99);
    op(`SFBC_OP_STAT, 200);
    check("size", protect_size_o, 3'h5);
    write_guard_n_i = 1'h0;
    send('{8'h06}, 99, 99);
    send('{8'h01, 8'h00}, 99, 99);
    repeat (250) @(negedge clk_i);
    check("frozen", protect_size_o, 3'h5);
    send('{8'h05, 8'h00}, 99, 12);
    check("status", rd_sh, 8'h94);
    send('{8'h06}, 99, 99);
    send('{8'hB9}, 99, 99);
    check("sleep", deep_sleep_o, 1'h1);
    send('{8'hC7}, 99, 99);
    check("ignored", cycle_active_flag_o, 1'h0);
    send('{8'hAB}, 99, 99);
    check("awake", deep_sleep_o, 1'h0);
    complete_run();
  end
endmodule // serial_flash_bus_control_tb
